// ---- rtl/xirq_det_if.sv ----
// Synchronised pin levels and falling-edge strobes between detector and controller
`timescale 1ns/100ps
`default_nettype none

interface xirq_det_if;
	logic [3:0] lvl;
	logic [3:0] fall;

	modport src (output lvl, output fall);
	modport snk (input lvl, input fall);
endinterface

`default_nettype wire

// ---- rtl/xirq_detect.sv ----
// Pin synchroniser and falling-edge detector for the port nibble
`timescale 1ns/100ps
`default_nettype none

module xirq_detect (
	input  wire logic       mclk,    // Core clock
	input  wire logic       resetn,  // Asynchronous reset, active low
	input  wire logic [3:0] pin_in,  // Raw pin levels
	xirq_det_if.src         det      // Synchronised levels and edges
);

	genvar i;
	generate
		for (i = 0; i < xirq_pkg::PORT_W; i++) begin : g_pin
			logic meta_ff;
			logic sync_ff;
			logic last_ff;

			// Idle high so release from reset raises no false edge
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					meta_ff <= xirq_pkg::PIN_IDLE[i];
					sync_ff <= xirq_pkg::PIN_IDLE[i];
					last_ff <= xirq_pkg::PIN_IDLE[i];
				end else begin
					meta_ff <= pin_in[i];
					sync_ff <= meta_ff;
					last_ff <= sync_ff;
				end
			end

			assign det.lvl[i]  = sync_ff;
			assign det.fall[i] = last_ff & ~sync_ff;
		end
	endgenerate

endmodule

`default_nettype wire

// ---- rtl/xirq_pkg.sv ----
// Constants and decode helpers for the extra external interrupt pair
package xirq_pkg;

	// Byte addresses in the special function space
	localparam logic [7:0] CTRL_ADDR     = 8'hc0;
	localparam logic [7:0] PORT_ADDR     = 8'hd8;

	// Bit-address bases: each bit-addressable register owns eight bit addresses
	localparam logic [7:0] CTRL_BIT_BASE = 8'hc0;
	localparam logic [7:0] PORT_BIT_BASE = 8'hd8;

	// Control register fields; channel c sits in the low nibble, channel d in the high
	localparam int CH_STRIDE  = 4;
	localparam int FLD_EDGE   = 0;
	localparam int FLD_PEND   = 1;
	localparam int FLD_EN     = 2;
	localparam int FLD_PRIO   = 3;
	localparam int NUM_CH     = 2;
	localparam int CH_C       = 0;
	localparam int CH_D       = 1;

	// Port nibble: channel c uses pin 3, channel d uses pin 2
	localparam int PORT_W     = 4;
	localparam int PIN_OF_CH0 = 3;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] PORT_RESET = 4'hf;
	localparam logic [3:0] PIN_IDLE   = 4'hf;

	// Vectors and polling positions within a priority level
	localparam logic [7:0] VEC_C  = 8'h33;
	localparam logic [7:0] VEC_D  = 8'h3b;
	localparam logic [2:0] POLL_C = 3'h6;
	localparam logic [2:0] POLL_D = 3'h7;

	// True when a bit address falls in the eight addresses of a register
	function automatic logic bit_hit(input logic [7:0] addr, input logic [7:0] base);
		bit_hit = (addr[7:3] == base[7:3]);
	endfunction

endpackage

// ---- rtl/xirq_top.sv ----
// Extra external interrupt pair with control register and shared port nibble
`timescale 1ns/100ps
`default_nettype none

module xirq_top (
	input  wire logic       mclk,                // Core clock, 100 MHz
	input  wire logic       resetn,              // Asynchronous reset, active low
	input  wire logic [7:0] sfr_addr,            // Byte address of special function access
	input  wire logic       sfr_wr,              // Byte write strobe
	input  wire logic [7:0] sfr_wdata,           // Byte write data
	input  wire logic       sfr_rd,              // Byte read strobe
	output logic      [7:0] sfr_rdata,           // Byte read data, one cycle after strobe
	input  wire logic [7:0] bit_addr,            // Bit address of bit instruction
	input  wire logic       bit_wr,              // Bit write strobe
	input  wire logic       bit_val,             // Value for bit write
	input  wire logic       bit_rd,              // Bit read strobe
	output logic            bit_rdata,           // Bit read data, one cycle after strobe
	input  wire logic       irq_c_serviced,      // Core took channel c vector
	input  wire logic       irq_d_serviced,      // Core took channel d vector
	output logic            irq_c_req,           // Channel c request to core
	output logic            irq_d_req,           // Channel d request to core
	output logic            irq_c_priority_high, // Channel c at high level
	output logic            irq_d_priority_high, // Channel d at high level
	output logic            irq_req,             // Either channel requesting
	output logic      [7:0] irq_vector,          // Vector of winning channel
	output logic            irq_prio_high,       // Winning channel at high level
	output logic      [2:0] irq_poll_index,      // Polling position of winner
	input  wire logic [3:0] nibble_io_port_in,   // Port pin levels
	output logic      [3:0] nibble_io_port_out,  // Port pin drive value
	output logic      [3:0] nibble_io_port_oe    // Port pin drive enable, high drives
);

	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [3:0] port_ff;
	logic [3:0] nxt_port;
	logic [7:0] rdata_ff;
	logic       bit_rdata_ff;
	logic [1:0] serviced;
	logic       win_d;
	logic       req_ff;
	logic [7:0] vec_ff;
	logic       prio_ff;
	logic [2:0] poll_ff;
	logic       ctrl_byte_wr;
	logic       ctrl_bit_wr;
	logic       port_byte_wr;
	logic       port_bit_wr;

	xirq_det_if det ();

	xirq_detect u_detect (
		.mclk   (mclk),
		.resetn (resetn),
		.pin_in (nibble_io_port_in),
		.det    (det)
	);

	assign serviced = {irq_d_serviced, irq_c_serviced};

	// Bit position of one field of one channel within the control register
	function automatic int fld(input int ch, input int f);
		fld = ch * xirq_pkg::CH_STRIDE + f;
	endfunction

	// Only the lower four port bit addresses have a latch behind them
	function automatic logic port_bit_hit(input logic [7:0] addr);
		port_bit_hit = xirq_pkg::bit_hit(addr, xirq_pkg::PORT_BIT_BASE) && !addr[2];
	endfunction

	// Write decode shared by both register updates
	assign ctrl_byte_wr = sfr_wr && (sfr_addr == xirq_pkg::CTRL_ADDR);
	assign ctrl_bit_wr  = bit_wr && xirq_pkg::bit_hit(bit_addr, xirq_pkg::CTRL_BIT_BASE);
	assign port_byte_wr = sfr_wr && (sfr_addr == xirq_pkg::PORT_ADDR);
	assign port_bit_wr  = bit_wr && port_bit_hit(bit_addr);

	// Software writes first, then hardware flag updates so a detected edge beats a clear
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (ctrl_byte_wr) begin
			nxt_ctrl = sfr_wdata;
		end
		if (ctrl_bit_wr) begin
			nxt_ctrl[bit_addr[2:0]] = bit_val;
		end
		for (int ch = 0; ch < xirq_pkg::NUM_CH; ch++) begin
			if (ctrl_ff[fld(ch, xirq_pkg::FLD_EDGE)]) begin
				if (serviced[ch]) begin
					nxt_ctrl[fld(ch, xirq_pkg::FLD_PEND)] = 1'b0;
				end
				if (det.fall[xirq_pkg::PIN_OF_CH0 - ch]) begin
					nxt_ctrl[fld(ch, xirq_pkg::FLD_PEND)] = 1'b1;
				end
			end else begin
				// Level mode sets pending while the pin is low; service does not clear it
				nxt_ctrl[fld(ch, xirq_pkg::FLD_PEND)] =
					~det.lvl[xirq_pkg::PIN_OF_CH0 - ch];
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= xirq_pkg::CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Port latch: a zero drives the pin low, a one releases it as an input
	always_comb begin
		nxt_port = port_ff;
		if (port_byte_wr) begin
			nxt_port = sfr_wdata[3:0];
		end
		if (port_bit_wr) begin
			nxt_port[bit_addr[1:0]] = bit_val;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			port_ff <= xirq_pkg::PORT_RESET;
		end else begin
			port_ff <= nxt_port;
		end
	end

	// Interrupt pins need the latch at one, otherwise the pin is held low
	// A zero there drives the pin low and so raises that channel's own request
	assign nibble_io_port_out = port_ff;
	assign nibble_io_port_oe  = ~port_ff;

	// Byte and bit reads; the port returns pin levels, not the latch
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_addr == xirq_pkg::CTRL_ADDR) begin
				rdata_ff <= ctrl_ff;
			end else if (sfr_addr == xirq_pkg::PORT_ADDR) begin
				rdata_ff <= {4'h0, det.lvl};
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bit_rdata_ff <= 1'b0;
		end else if (bit_rd) begin
			if (xirq_pkg::bit_hit(bit_addr, xirq_pkg::CTRL_BIT_BASE)) begin
				bit_rdata_ff <= ctrl_ff[bit_addr[2:0]];
			end else if (port_bit_hit(bit_addr)) begin
				bit_rdata_ff <= det.lvl[bit_addr[1:0]];
			end else begin
				bit_rdata_ff <= 1'b0;
			end
		end
	end

	assign sfr_rdata = rdata_ff;
	assign bit_rdata = bit_rdata_ff;

	// Per-channel requests gated by enable
	assign irq_c_req = ctrl_ff[xirq_pkg::CH_C * xirq_pkg::CH_STRIDE + xirq_pkg::FLD_EN]
		& ctrl_ff[xirq_pkg::CH_C * xirq_pkg::CH_STRIDE + xirq_pkg::FLD_PEND];
	assign irq_d_req = ctrl_ff[xirq_pkg::CH_D * xirq_pkg::CH_STRIDE + xirq_pkg::FLD_EN]
		& ctrl_ff[xirq_pkg::CH_D * xirq_pkg::CH_STRIDE + xirq_pkg::FLD_PEND];
	assign irq_c_priority_high =
		ctrl_ff[xirq_pkg::CH_C * xirq_pkg::CH_STRIDE + xirq_pkg::FLD_PRIO];
	assign irq_d_priority_high =
		ctrl_ff[xirq_pkg::CH_D * xirq_pkg::CH_STRIDE + xirq_pkg::FLD_PRIO];

	// Channel d only wins when it alone requests or outranks channel c
	// Equal levels go to channel c, which is polled ahead of d
	assign win_d = irq_d_req
		&& (!irq_c_req || (irq_d_priority_high && !irq_c_priority_high));

	// Registered winner so vector, level and poll index change together
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			req_ff  <= 1'b0;
			vec_ff  <= 8'h00;
			prio_ff <= 1'b0;
			poll_ff <= 3'h0;
		end else begin
			req_ff <= irq_c_req | irq_d_req;
			if (win_d) begin
				vec_ff  <= xirq_pkg::VEC_D;
				prio_ff <= irq_d_priority_high;
				poll_ff <= xirq_pkg::POLL_D;
			end else begin
				vec_ff  <= xirq_pkg::VEC_C;
				prio_ff <= irq_c_priority_high;
				poll_ff <= xirq_pkg::POLL_C;
			end
		end
	end

	assign irq_req        = req_ff;
	assign irq_vector     = vec_ff;
	assign irq_prio_high  = prio_ff;
	assign irq_poll_index = poll_ff;

endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the extra interrupt pair
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       mclk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0;
	logic       bit_val = 1'b0, bit_rd = 1'b0, irq_c_serviced = 1'b0, irq_d_serviced = 1'b0;
	logic       bit_rdata, rb, irq_c_req, irq_d_req, irq_req, irq_prio_high;
	logic       irq_c_priority_high, irq_d_priority_high;
	logic [1:0] pull = 2'b00;
	logic [2:0] irq_poll_index;
	logic [3:0] pin, port_out, port_oe;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
	logic [7:0] sfr_rdata, irq_vector, rv;
	int         n_errors = 0, checks = 0, cycles = 0;
	always #5 mclk = ~mclk;
	xirq_top u_xirq_top (.*, .nibble_io_port_in(pin), .nibble_io_port_out(port_out),
		.nibble_io_port_oe(port_oe));
	xirq_pins u_xirq_pins (.out(port_out), .oe(port_oe), .pull(pull), .pin(pin));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask
	task automatic bw(input logic [7:0] a, input logic v);
		@(posedge mclk);
		bit_addr <= a;
		bit_val <= v;
		bit_wr <= 1'b1;
		@(posedge mclk);
		bit_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] b);
		@(posedge mclk);
		sfr_addr <= a;
		bit_addr <= b;
		sfr_rd <= 1'b1;
		bit_rd <= 1'b1;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		bit_rd <= 1'b0;
		#1;
		rv = sfr_rdata;
		rb = bit_rdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic svc(input logic ch);
		@(posedge mclk);
		irq_c_serviced <= !ch;
		irq_d_serviced <= ch;
		@(posedge mclk);
		irq_c_serviced <= 1'b0;
		irq_d_serviced <= 1'b0;
		tick(1);
	endtask
	task automatic reg_test;
		logic [7:0] exp;
		exp = 8'h00;
		rd(8'hc0, 8'h55);
		chk({rv[7:1], rb}, 8'h00);
		rd(8'hd8, 8'hd8);
		chk({rv[7:1], rb}, 8'h0f);
		for (int i = 0; i < 8; i += (i % 4 == 0) ? 2 : 1) begin
			bw(8'hc0 + 8'(i), 1'b1);
			exp[i] = 1'b1;
			rd(8'hc0, 8'hc0 + 8'(i));
			chk({rv[7:1], rv[0] & rb}, exp);
		end
		chk({6'h0, irq_d_priority_high, irq_c_priority_high}, 8'h03);
		bw(8'hc3, 1'b0);
		bw(8'hc2, 1'b0);
		bw(8'hc6, 1'b0);
		rd(8'hc0, 8'hc0);
		chk(rv, 8'h91);
		wr(8'hc0, 8'h00);
	endtask
	task automatic port_test;
		bw(8'hd8, 1'b0);
		tick(3);
		chk({port_oe, port_out}, 8'h1e);
		rd(8'hd8, 8'hd8);
		chk({rv[7:1], rb}, 8'h0e);
		bw(8'hd8, 1'b1);
		wr(8'hd8, 8'h0d);
		bw(8'hdc, 1'b0);
		tick(1);
		chk({port_oe, port_out}, 8'h2d);
		rd(8'hd8, 8'hd9);
		chk({rv[7:1], rb}, 8'h0c);
		rd(8'hd9, 8'hdc);
		chk({rv[7:1], rb}, 8'h00);
		wr(8'hd8, 8'h0f);
	endtask
	task automatic edge_run(input logic ch);
		wr(8'hc0, ch ? 8'h50 : 8'h05);
		pull[ch] <= 1'b1;
		for (int i = 0; i < 8 && (ch ? irq_d_req : irq_c_req) !== 1'b1; i++)
			tick(1);
		tick(1);
		chk({irq_req, irq_vector[6:0]}, ch ? 8'hbb : 8'hb3);
		chk(8'(irq_poll_index), ch ? 8'h07 : 8'h06);
		svc(ch);
		chk(8'(ch ? irq_d_req : irq_c_req), 8'h00);
		wr(8'hc0, ch ? 8'h10 : 8'h01);
		pull[ch] <= 1'b0;
		tick(4);
		pull[ch] <= 1'b1;
		tick(5);
		rd(8'hc0, ch ? 8'hc5 : 8'hc1);
		chk({rv[7:1], rb}, ch ? 8'h31 : 8'h03);
		chk(8'(ch ? irq_d_req : irq_c_req), 8'h00);
		pull[ch] <= 1'b0;
		wr(8'hc0, 8'h00);
	endtask
	task automatic level_test;
		wr(8'hc0, 8'h40);
		pull[1] <= 1'b1;
		tick(5);
		chk(8'(irq_d_req), 8'h01);
		svc(1'b1);
		chk(8'(irq_d_req), 8'h01);
		wr(8'hc0, 8'hc4);
		pull[0] <= 1'b1;
		tick(6);
		chk({irq_prio_high, irq_vector[6:0]}, 8'hbb);
		wr(8'hc0, 8'h4c);
		tick(3);
		chk({irq_prio_high, irq_vector[6:0]}, 8'hb3);
		pull <= 2'b00;
		tick(5);
		chk(8'(irq_req), 8'h00);
	endtask
	task automatic reset_test;
		wr(8'hc0, 8'hdd);
		wr(8'hd8, 8'h00);
		tick(5);
		chk({irq_req, irq_vector[6:0]}, 8'hb3);
		@(posedge mclk);
		resetn <= 1'b0;
		tick(2);
		chk({irq_c_req, irq_d_req, irq_req, irq_prio_high, 1'b0, irq_poll_index}, 8'h00);
		chk({port_oe, port_out}, 8'h0f);
		@(posedge mclk);
		resetn <= 1'b1;
		rd(8'hc0, 8'hc0);
		chk({rv[7:1], rb}, 8'h00);
	endtask
	task automatic complete_run;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Whole run needs under two hundred cycles; far beyond that means a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		reg_test();
		port_test();
		edge_run(1'b0);
		edge_run(1'b1);
		level_test();
		reset_test();
		complete_run();
	end
endmodule
`default_nettype wire

// ---- tb/xirq_checker.sv ----
// Port assertions for the extra interrupt pair
`timescale 1ns/100ps
`default_nettype none
module xirq_checker (
	input wire logic       mclk,                // Clock
	input wire logic       resetn,              // Reset
	input wire logic [7:0] bit_addr,            // Bit addr
	input wire logic       bit_wr,              // Bit write
	input wire logic       bit_val,             // Bit value
	input wire logic       irq_c_req,           // Req c
	input wire logic       irq_d_req,           // Req d
	input wire logic       irq_c_priority_high, // Prio c
	input wire logic       irq_d_priority_high, // Prio d
	input wire logic       irq_req,             // Any req
	input wire logic [7:0] irq_vector,          // Vector
	input wire logic       irq_prio_high,       // Winner prio
	input wire logic [2:0] irq_poll_index,      // Poll slot
	input wire logic [3:0] nibble_io_port_out   // Port value
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// Ties go to c because it is polled first
	sequence s_c_wins;
		irq_c_req && !(irq_d_req && irq_d_priority_high && !irq_c_priority_high);
	endsequence
	sequence s_d_wins;
		irq_d_req && !irq_c_req;
	endsequence
	property p_c_vec;
		s_c_wins |=> irq_req && irq_vector == 8'h33 && irq_poll_index == 3'h6;
	endproperty
	a_c_vec: assert property (p_c_vec) else $error("c winner wrong");
	property p_d_vec;
		s_d_wins |=> irq_vector == 8'h3b && irq_poll_index == 3'h7
			&& irq_prio_high == $past(irq_d_priority_high);
	endproperty
	a_d_vec: assert property (p_d_vec) else $error("d winner wrong");
	property p_idle;
		!irq_c_req && !irq_d_req |=> !irq_req;
	endproperty
	a_idle: assert property (p_idle) else $error("spurious request");
	property p_c_off;
		bit_wr && bit_addr == 8'hc2 && !bit_val |=> !irq_c_req;
	endproperty
	a_c_off: assert property (p_c_off) else $error("c req while off");
	property p_d_off;
		bit_wr && bit_addr == 8'hc6 && !bit_val |=> !irq_d_req;
	endproperty
	a_d_off: assert property (p_d_off) else $error("d req while off");
	property p_c_pri;
		bit_wr && bit_addr == 8'hc3 |=> irq_c_priority_high == $past(bit_val);
	endproperty
	a_c_pri: assert property (p_c_pri) else $error("c prio wrong");
	property p_d_pri;
		bit_wr && bit_addr == 8'hc7 |=> irq_d_priority_high == $past(bit_val);
	endproperty
	a_d_pri: assert property (p_d_pri) else $error("d prio wrong");
	property p_port;
		bit_wr && bit_addr == 8'hd8 |=> nibble_io_port_out[0] == $past(bit_val);
	endproperty
	a_port: assert property (p_port) else $error("port bit wrong");
endmodule
bind xirq_top xirq_checker u_xirq_checker (.*);
`default_nettype wire

// ---- tb/xirq_pins.sv ----
// Pin-side model: external sources that pull request pins low, plus pull-ups
`timescale 1ns/100ps
`default_nettype none
module xirq_pins (
	input  wire logic [3:0] out,  // Port drive value
	input  wire logic [3:0] oe,   // Port drive enable
	input  wire logic [1:0] pull, // Source holds d (1) or c (0) pin low
	output logic      [3:0] pin   // Resolved levels
);
	// Wired-low: any party pulling low wins, otherwise the pull-up sets the level
	assign pin = ~(oe & ~out) & ~{pull[0], pull[1], 2'b00};
endmodule
`default_nettype wire
